// file: design/flash_ctl_pkg.sv
// Constants, register map and state type of the flash program/erase control block
package flash_ctl_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MODE_CTL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OP_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_BLK_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_BLK_HIGH = 4'h3;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Mode control fields
  // ----------------------------------------------------------------
  localparam int BIT_RSVD7 = 7;
  localparam int BIT_UNLOCK = 6;
  localparam int BIT_WIPE_PREP = 5;
  localparam int BIT_WRITE_PREP = 4;
  localparam int BIT_WIPE_CHECK = 3;
  localparam int BIT_WRITE_CHECK = 2;
  localparam int BIT_WIPE_RUN = 1;
  localparam int BIT_WRITE_RUN = 0;

  // ----------------------------------------------------------------
  // Status and block select fields
  // ----------------------------------------------------------------
  localparam int BIT_FAULT = 7;
  localparam int LOW_BLOCKS = 8;
  localparam int HIGH_BLOCKS = 2;
  localparam int NUM_BLOCKS = LOW_BLOCKS + HIGH_BLOCKS;
  localparam int FADDR_W = 24;
  localparam int SIZE_W = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [NUM_BLOCKS-1:0] SEL_NONE = 10'h000;
  localparam logic [NUM_BLOCKS-1:0] SEL_ONE = 10'h001;
  localparam logic [FADDR_W-1:0] BASE_NONE = 24'h00_0000;
  localparam logic [SIZE_W-1:0] SIZE_NONE = 6'h00;

  // ----------------------------------------------------------------
  // Erase block map, index = select bit
  // ----------------------------------------------------------------
  localparam logic [FADDR_W-1:0] BLK_BASE [NUM_BLOCKS] = '{
    24'h00_0000, 24'h00_0400, 24'h00_0800, 24'h00_0c00, 24'h00_1000,
    24'h00_8000, 24'h00_c000, 24'h00_e000, 24'h01_0000, 24'h01_8000
  };
  localparam logic [SIZE_W-1:0] BLK_SIZE_KB [NUM_BLOCKS] = '{
    6'h01, 6'h01, 6'h01, 6'h01, 6'h1c, 6'h10, 6'h08, 6'h08, 6'h20, 6'h20
  };

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic program_unlock;
    logic wipe_prep;
    logic write_prep;
    logic wipe_check;
    logic write_check;
    logic wipe_run;
    logic write_run;
    logic op_fault_flag;
    logic [LOW_BLOCKS-1:0] blk_low;
    logic [HIGH_BLOCKS-1:0] blk_high;
    logic [FADDR_W-1:0] erase_base;
    logic [SIZE_W-1:0] erase_size_kb;
    logic [DATA_W-1:0] rdata;
  } state_t;

endpackage

// file: design/blk_map_if.sv
// Carrier between the control registers and the erase block decoder
`timescale 1ns/1ps
interface blk_map_if;
  import flash_ctl_pkg::*;
  logic [NUM_BLOCKS-1:0] sel;
  logic multi;
  logic [FADDR_W-1:0] base;
  logic [SIZE_W-1:0] size_kb;
  modport requester (output sel, input multi, input base, input size_kb);
  modport mapper (input sel, output multi, output base, output size_kb);
endinterface

// file: design/erase_block_map.sv
// Decoder from erase block selection to area base and size
`timescale 1ns/1ps
module erase_block_map (
  blk_map_if.mapper map
);
  import flash_ctl_pkg::*;

  logic [FADDR_W-1:0] base_term [NUM_BLOCKS];
  logic [SIZE_W-1:0] size_term [NUM_BLOCKS];

  // ----------------------------------------------------------------
  // Per-block masked terms
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
    assign base_term[i] = {FADDR_W{map.sel[i]}} & BLK_BASE[i];
    assign size_term[i] = {SIZE_W{map.sel[i]}} & BLK_SIZE_KB[i];
  end

  // Valid only for a single set bit; callers discard it otherwise
  always_comb begin
    map.base = BASE_NONE;
    map.size_kb = SIZE_NONE;
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      map.base = map.base | base_term[i];
      map.size_kb = map.size_kb | size_term[i];
    end
  end

  // More than one bit set
  assign map.multi = (map.sel & (map.sel - SEL_ONE)) != SEL_NONE;

endmodule

// file: design/flash_program_erase_control.sv
// Control and status registers of the flash program/erase sequencer
//
// How it works
// - Unlock bit 6 permits program/erase; while clear no other control bit and no block select can be set.
// - Bit 5 enters erase setup when written 1, leaves when written 0.
// - Bit 4 enters program setup when written 1, leaves when written 0.
// - Bit 3 enters erase-verify when set, cancels it when cleared.
// - Bit 2 enters program-verify when set, cancels it when cleared.
// - Bit 1 starts erase only when unlock and erase setup already are 1.
// - Bit 0 starts program only when unlock and program setup already are 1.
// - Control bit 7 is reserved and always reads 0.
// - Status bit 7 sets on an operation error and holds error protection.
// - Status bits 6 to 0 are reserved and read 0.
// - Low block select is forced to zero while unlock is 0.
// - More than one set select bit clears both select registers.
// - Low select bits 7 and 6 pick the two 8-Kbyte blocks.
// - Low select bits 5 and 4 pick the 16- and 28-Kbyte blocks.
// - Low select bits 3 to 0 pick the four 1-Kbyte blocks.
`timescale 1ns/1ps
module flash_program_erase_control (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [flash_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_ctl_pkg::DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [flash_ctl_pkg::DATA_W-1:0] rdata,
  input wire logic op_error,
  output logic erase_setup,
  output logic program_setup,
  output logic erase_verify,
  output logic program_verify,
  output logic erase_active,
  output logic program_active,
  output logic error_protect,
  output logic [flash_ctl_pkg::NUM_BLOCKS-1:0] erase_blocks,
  output logic [flash_ctl_pkg::FADDR_W-1:0] erase_base,
  output logic [flash_ctl_pkg::SIZE_W-1:0] erase_size_kb
);
  import flash_ctl_pkg::*;

  state_t s_r;
  state_t s_nxt;
  logic wr_ctl;
  logic wr_low;
  logic wr_high;
  logic wr_status;
  logic rd_ctl;
  logic rd_status;
  logic [LOW_BLOCKS-1:0] cand_low;
  logic [HIGH_BLOCKS-1:0] cand_high;

  blk_map_if map_if ();

  erase_block_map u_map (
    .map(map_if.mapper)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_ctl = we && (addr == OFS_MODE_CTL);
  assign wr_status = we && (addr == OFS_OP_STATUS);
  assign wr_low = we && (addr == OFS_BLK_LOW);
  assign wr_high = we && (addr == OFS_BLK_HIGH);
  assign rd_ctl = re && (addr == OFS_MODE_CTL);
  assign rd_status = re && (addr == OFS_OP_STATUS);

  // Candidate selection after this cycle's write, before the checks
  assign cand_low = wr_low ? wdata[LOW_BLOCKS-1:0] : s_r.blk_low;
  assign cand_high = wr_high ? wdata[HIGH_BLOCKS-1:0] : s_r.blk_high;
  assign map_if.sel = {cand_high, cand_low};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = READ_UNMAPPED;
    if (re) begin
      case (addr)
        OFS_MODE_CTL: begin
          s_nxt.rdata = RST_BYTE;
          s_nxt.rdata[BIT_RSVD7] = 1'b0;
          s_nxt.rdata[BIT_UNLOCK] = s_r.program_unlock;
          s_nxt.rdata[BIT_WIPE_PREP] = s_r.wipe_prep;
          s_nxt.rdata[BIT_WRITE_PREP] = s_r.write_prep;
          s_nxt.rdata[BIT_WIPE_CHECK] = s_r.wipe_check;
          s_nxt.rdata[BIT_WRITE_CHECK] = s_r.write_check;
          s_nxt.rdata[BIT_WIPE_RUN] = s_r.wipe_run;
          s_nxt.rdata[BIT_WRITE_RUN] = s_r.write_run;
        end
        OFS_OP_STATUS: begin
          s_nxt.rdata = RST_BYTE;
          s_nxt.rdata[BIT_FAULT] = s_r.op_fault_flag;
        end
        OFS_BLK_LOW: begin
          s_nxt.rdata = s_r.blk_low;
        end
        OFS_BLK_HIGH: begin
          s_nxt.rdata = RST_BYTE;
          s_nxt.rdata[HIGH_BLOCKS-1:0] = s_r.blk_high;
        end
        default: begin
          s_nxt.rdata = READ_UNMAPPED;
        end
      endcase
    end

    // Sticky; only reset leaves error protection
    s_nxt.op_fault_flag = s_r.op_fault_flag | op_error;
    // Status writes fall through: no field takes them
    if (wr_status) begin
      s_nxt.op_fault_flag = s_r.op_fault_flag | op_error;
    end

    if (wr_ctl) begin
      s_nxt.program_unlock = wdata[BIT_UNLOCK];
      s_nxt.wipe_prep = wdata[BIT_WIPE_PREP];
      s_nxt.write_prep = wdata[BIT_WRITE_PREP];
      s_nxt.wipe_check = wdata[BIT_WIPE_CHECK];
      s_nxt.write_check = wdata[BIT_WRITE_CHECK];
      // Run bits look at the bits already held, so setup must come first
      s_nxt.wipe_run = wdata[BIT_WIPE_RUN] &&
                       (s_r.wipe_run || (s_r.program_unlock && s_r.wipe_prep));
      s_nxt.write_run = wdata[BIT_WRITE_RUN] &&
                        (s_r.write_run || (s_r.program_unlock && s_r.write_prep));
    end

    // Locked: every other control bit drops and none can be set
    if (!s_nxt.program_unlock) begin
      s_nxt.wipe_prep = 1'b0;
      s_nxt.write_prep = 1'b0;
      s_nxt.wipe_check = 1'b0;
      s_nxt.write_check = 1'b0;
      s_nxt.wipe_run = 1'b0;
      s_nxt.write_run = 1'b0;
    end

    // Error protection stops any running operation
    if (s_nxt.op_fault_flag) begin
      s_nxt.wipe_run = 1'b0;
      s_nxt.write_run = 1'b0;
    end

    s_nxt.blk_low = cand_low;
    s_nxt.blk_high = cand_high;
    if (map_if.multi) begin
      s_nxt.blk_low = RST_BYTE[LOW_BLOCKS-1:0];
      s_nxt.blk_high = RST_BYTE[HIGH_BLOCKS-1:0];
    end
    if (!s_nxt.program_unlock) begin
      s_nxt.blk_low = RST_BYTE[LOW_BLOCKS-1:0];
      s_nxt.blk_high = RST_BYTE[HIGH_BLOCKS-1:0];
    end

    // Decoded area follows the final selection in the same edge
    if ({s_nxt.blk_high, s_nxt.blk_low} != SEL_NONE) begin
      s_nxt.erase_base = map_if.base;
      s_nxt.erase_size_kb = map_if.size_kb;
    end else begin
      s_nxt.erase_base = BASE_NONE;
      s_nxt.erase_size_kb = SIZE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = s_r.rdata;
  assign erase_setup = s_r.wipe_prep;
  assign program_setup = s_r.write_prep;
  assign erase_verify = s_r.wipe_check;
  assign program_verify = s_r.write_check;
  assign erase_active = s_r.wipe_run;
  assign program_active = s_r.write_run;
  assign error_protect = s_r.op_fault_flag;
  assign erase_blocks = {s_r.blk_high, s_r.blk_low};
  assign erase_base = s_r.erase_base;
  assign erase_size_kb = s_r.erase_size_kb;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ctl_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_ctl |=> rdata[BIT_RSVD7] == 1'b0)
    else $error("reserved control bit read as one");

  a_status_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_status |=> rdata[BIT_FAULT-1:0] == 7'h00 && rdata[BIT_FAULT] == $past(s_r.op_fault_flag))
    else $error("status read data wrong");

  a_lock_clears_ctl: assert property (@(posedge clk) disable iff (!rstn)
    !s_r.program_unlock |-> !(erase_setup || program_setup || erase_verify ||
                              program_verify || erase_active || program_active))
    else $error("control bit set while locked");

  a_lock_clears_blk: assert property (@(posedge clk) disable iff (!rstn)
    (!s_r.program_unlock && !wr_ctl) || (wr_ctl && !wdata[BIT_UNLOCK]) |=>
      erase_blocks == SEL_NONE)
    else $error("block select set while locked");

  a_setup_follow: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && wdata[BIT_UNLOCK] |=>
      erase_setup == $past(wdata[BIT_WIPE_PREP]) &&
      program_setup == $past(wdata[BIT_WRITE_PREP]))
    else $error("setup bit did not follow write");

  a_verify_follow: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && wdata[BIT_UNLOCK] |=>
      erase_verify == $past(wdata[BIT_WIPE_CHECK]) &&
      program_verify == $past(wdata[BIT_WRITE_CHECK]))
    else $error("verify bit did not follow write");

  a_erase_gate: assert property (@(posedge clk) disable iff (!rstn)
    $rose(erase_active) |->
      $past(s_r.program_unlock) && $past(s_r.wipe_prep) && $past(wr_ctl))
    else $error("erase started without unlock and setup");

  a_program_gate: assert property (@(posedge clk) disable iff (!rstn)
    $rose(program_active) |->
      $past(s_r.program_unlock) && $past(s_r.write_prep) && $past(wr_ctl))
    else $error("program started without unlock and setup");

  a_fault_sets: assert property (@(posedge clk) disable iff (!rstn)
    op_error |=> error_protect [*3])
    else $error("error flag not set and held");

  a_fault_protects: assert property (@(posedge clk) disable iff (!rstn)
    error_protect |-> !erase_active && !program_active)
    else $error("operation running in error protection");

  a_status_wr_ignored: assert property (@(posedge clk) disable iff (!rstn)
    wr_status && !op_error |=> error_protect == $past(error_protect))
    else $error("status write changed the flag");

  a_blk_one_hot: assert property (@(posedge clk) disable iff (!rstn)
    $onehot0(erase_blocks))
    else $error("more than one erase block selected");

  a_blk_base: assert property (@(posedge clk) disable iff (!rstn)
    s_r.blk_low[LOW_BLOCKS-1] |-> erase_base == BLK_BASE[LOW_BLOCKS-1] &&
                                 erase_size_kb == BLK_SIZE_KB[LOW_BLOCKS-1])
    else $error("top low block decoded wrong");

  // ----------------------------------------------------------------
  // Read path, run gating and selection checks
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !re |=> rdata == READ_UNMAPPED)
    else $error("read data not zero outside a read");

  a_ctl_readback: assert property (@(posedge clk) disable iff (!rstn)
    rd_ctl |=>
      rdata[BIT_WIPE_PREP] == $past(erase_setup) &&
      rdata[BIT_WRITE_PREP] == $past(program_setup) &&
      rdata[BIT_WIPE_CHECK] == $past(erase_verify) &&
      rdata[BIT_WRITE_CHECK] == $past(program_verify))
    else $error("control read data differs from state");

  a_run_readback: assert property (@(posedge clk) disable iff (!rstn)
    rd_ctl |=>
      rdata[BIT_WIPE_RUN] == $past(erase_active) &&
      rdata[BIT_WRITE_RUN] == $past(program_active))
    else $error("run bits read back wrong");

  a_blk_low_readback: assert property (@(posedge clk) disable iff (!rstn)
    re && addr == OFS_BLK_LOW |=> rdata == $past(s_r.blk_low))
    else $error("low block select read back wrong");

  a_blk_high_readback: assert property (@(posedge clk) disable iff (!rstn)
    re && addr == OFS_BLK_HIGH |=>
      rdata[DATA_W-1:HIGH_BLOCKS] == RST_BYTE[DATA_W-1:HIGH_BLOCKS] &&
      rdata[HIGH_BLOCKS-1:0] == $past(s_r.blk_high))
    else $error("high block select read back wrong");

  a_erase_start: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && wdata[BIT_UNLOCK] && wdata[BIT_WIPE_RUN] && s_r.program_unlock &&
      s_r.wipe_prep && !op_error && !error_protect |=> erase_active)
    else $error("erase did not start");

  a_program_start: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && wdata[BIT_UNLOCK] && wdata[BIT_WRITE_RUN] && s_r.program_unlock &&
      s_r.write_prep && !op_error && !error_protect |=> program_active)
    else $error("program did not start");

  a_erase_stop: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && !wdata[BIT_WIPE_RUN] |=> !erase_active)
    else $error("erase did not stop");

  a_program_stop: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && !wdata[BIT_WRITE_RUN] |=> !program_active)
    else $error("program did not stop");

  a_erase_setup_first: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && !s_r.wipe_prep && !s_r.wipe_run |=> !erase_active)
    else $error("erase started without prior setup");

  a_program_setup_first: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && !s_r.write_prep && !s_r.write_run |=> !program_active)
    else $error("program started without prior setup");

  a_lock_write_clears: assert property (@(posedge clk) disable iff (!rstn)
    wr_ctl && !wdata[BIT_UNLOCK] |=>
      erase_blocks == SEL_NONE && !erase_setup && !program_setup)
    else $error("lock write left bits set");

  a_multi_clears: assert property (@(posedge clk) disable iff (!rstn)
    map_if.multi |=> erase_blocks == SEL_NONE)
    else $error("multiple selection not cleared");

  a_blk_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    wr_low && s_r.program_unlock && !map_if.multi |=>
      erase_blocks[LOW_BLOCKS-1:0] == $past(wdata))
    else $error("low block select write lost");

  a_base_none: assert property (@(posedge clk) disable iff (!rstn)
    erase_blocks == SEL_NONE |-> erase_base == BASE_NONE && erase_size_kb == SIZE_NONE)
    else $error("area decoded without a selection");

  a_fault_sticky: assert property (@(posedge clk) disable iff (!rstn)
    error_protect |=> error_protect)
    else $error("error flag cleared without reset");

  // One check per block, so a select bit decoded to the wrong table entry shows up
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk_chk
    a_blk_decode: assert property (@(posedge clk) disable iff (!rstn)
      erase_blocks == (SEL_ONE << b) |->
        erase_base == BLK_BASE[b] && erase_size_kb == BLK_SIZE_KB[b])
      else $error("erase block decoded wrong");
  end

endmodule

// file: testbench/tb.sv
// Self-checking bench for the flash program/erase control registers
`timescale 1ns/1ps
module tb;
  import flash_ctl_pkg::*;
  logic clk, rstn, we, re, op_error;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic erase_setup, program_setup, erase_verify, program_verify;
  logic erase_active, program_active, error_protect;
  logic [NUM_BLOCKS-1:0] erase_blocks;
  logic [FADDR_W-1:0] erase_base;
  logic [SIZE_W-1:0] erase_size_kb;
  int n_errors, n_compared;
  logic [7:0] cw [14] = '{8'h3f, 8'h40, 8'h42, 8'h60, 8'h62, 8'h40, 8'h51,
                          8'h51, 8'h50, 8'h40, 8'h48, 8'h44, 8'hc0, 8'h00};
  logic [7:0] ce [14] = '{8'h00, 8'h40, 8'h40, 8'h60, 8'h62, 8'h40, 8'h50,
                          8'h51, 8'h50, 8'h40, 8'h48, 8'h44, 8'h40, 8'h00};

  flash_program_erase_control u_flash_program_erase_control (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .op_error(op_error), .erase_setup(erase_setup),
    .program_setup(program_setup), .erase_verify(erase_verify),
    .program_verify(program_verify), .erase_active(erase_active),
    .program_active(program_active), .error_protect(error_protect),
    .erase_blocks(erase_blocks), .erase_base(erase_base),
    .erase_size_kb(erase_size_kb)
  );

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  // Own copy of the block map, so a wrong table in the design shows up
  function automatic logic [29:0] map_exp(input logic [9:0] s);
    if (!$onehot(s)) return 30'h0;
    for (int i = 0; i < 10; i++) begin
      if (s[i]) begin
        case (i)
          0: return {24'h00_0000, 6'h01};
          1: return {24'h00_0400, 6'h01};
          2: return {24'h00_0800, 6'h01};
          3: return {24'h00_0c00, 6'h01};
          4: return {24'h00_1000, 6'h1c};
          5: return {24'h00_8000, 6'h10};
          6: return {24'h00_c000, 6'h08};
          7: return {24'h00_e000, 6'h08};
          8: return {24'h01_0000, 6'h20};
          default: return {24'h01_8000, 6'h20};
        endcase
      end
    end
    return 30'h0;
  endfunction

  task automatic chk(input logic [29:0] got, input logic [29:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Outputs settle one cycle after the strobe edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk({22'h0, rdata}, {22'h0, e});
  endtask

  task automatic ctl_is(input logic [7:0] e);
    rd(OFS_MODE_CTL, e);
    chk({24'h0, erase_setup, program_setup, erase_verify, program_verify,
         erase_active, program_active}, {24'h0, e[5:0]});
  endtask

  task automatic blk_is(input logic [7:0] lo, input logic [1:0] hi);
    rd(OFS_BLK_LOW, lo);
    rd(OFS_BLK_HIGH, {6'h00, hi});
    chk({20'h0, erase_blocks}, {20'h0, hi, lo});
    chk({erase_base, erase_size_kb}, map_exp({hi, lo}));
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    rstn = 1'b0;
    we = 1'b0;
    re = 1'b0;
    op_error = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    void'($urandom(89540));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    ctl_is(8'h00);
    rd(OFS_OP_STATUS, 8'h00);
    blk_is(8'h00, 2'h0);
    wr(4'hf, 8'hff);
    rd(4'hf, READ_UNMAPPED);
    wr(OFS_OP_STATUS, 8'hff);
    rd(OFS_OP_STATUS, 8'h00);
    chk({29'h0, error_protect}, 30'h0);
    $display("test reset done");

    for (int i = 0; i < 14; i++) begin
      wr(OFS_MODE_CTL, cw[i]);
      ctl_is(ce[i]);
    end
    $display("test control done");

    wr(OFS_BLK_LOW, 8'h01);
    blk_is(8'h00, 2'h0);
    wr(OFS_MODE_CTL, 8'h40);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_BLK_LOW, 8'h01 << i);
      blk_is(8'h01 << i, 2'h0);
    end
    wr(OFS_BLK_LOW, 8'h00);
    wr(OFS_BLK_HIGH, 8'h02);
    blk_is(8'h00, 2'h2);
    wr(OFS_BLK_HIGH, 8'h01);
    blk_is(8'h00, 2'h1);
    // Second bit lands in the other register: both must clear
    wr(OFS_BLK_LOW, 8'h80);
    blk_is(8'h00, 2'h0);
    wr(OFS_BLK_LOW, 8'h03);
    blk_is(8'h00, 2'h0);
    wr(OFS_BLK_LOW, 8'h10);
    wr(OFS_MODE_CTL, 8'h00);
    blk_is(8'h00, 2'h0);
    $display("test blocks done");

    wr(OFS_MODE_CTL, 8'h40);
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom());
      if (i % 2 == 0) v = 8'h01 << ($urandom() % 8);
      wr(OFS_BLK_LOW, v);
      blk_is($onehot(v) ? v : 8'h00, 2'h0);
    end
    $display("test random done");

    wr(OFS_MODE_CTL, 8'h50);
    wr(OFS_MODE_CTL, 8'h51);
    ctl_is(8'h51);
    @(posedge clk);
    op_error <= 1'b1;
    @(posedge clk);
    op_error <= 1'b0;
    #1;
    chk({28'h0, error_protect, program_active}, 30'h2);
    rd(OFS_OP_STATUS, 8'h80);
    // Status is read-only: a stray write must not clear the fault
    wr(OFS_OP_STATUS, 8'h00);
    rd(OFS_OP_STATUS, 8'h80);
    wr(OFS_MODE_CTL, 8'h51);
    ctl_is(8'h50);
    $display("test fault done");
    // Only reset leaves error protection
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_OP_STATUS, 8'h00);
    ctl_is(8'h00);
    blk_is(8'h00, 2'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
